// ===== tfa_pkg.sv
// package: constants and types for the timer flag and conflict arbiter
package tfa_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00; // counter_control_reg
  localparam logic [7:0] OFS_FUNC = 8'h04; // function_control_reg
  localparam logic [7:0] OFS_IOEN = 8'h08; // pin direction / toggle
  localparam logic [7:0] OFS_OLVL = 8'h0C; // output_level_control_reg
  localparam logic [7:0] OFS_STAT = 8'h10; // status flags
  localparam logic [7:0] OFS_MASK = 8'h14; // interrupt enables
  localparam logic [7:0] OFS_CNT = 8'h18; // timer_count_value
  localparam logic [7:0] OFS_GR0 = 8'h20; // general_compare_reg 0..3
  localparam logic [7:0] OFS_GR_STEP = 8'h04;

  // counter_control_reg fields
  localparam int CTRL_RUN = 0;
  localparam int CTRL_PSC_LO = 1;
  localparam int CTRL_CLR = 4; // clear on reg 0 match or capture

  // io enable register: low nibble output enable, high nibble toggle
  localparam int IOEN_TGL_LO = 4;

  // status / mask layout
  localparam int STAT_OVF = 4;
  localparam int NUM_FLAGS = 5;

  // prescaler select codes
  localparam logic [2:0] PSC_EXT_RISE = 3'h6;
  localparam logic [2:0] PSC_EXT_FALL = 3'h7;

  // reset values
  localparam logic [15:0] RST_ZERO = 16'h0000;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } tfa_bus_req_t;

endpackage : tfa_pkg

// ===== tfa_pin_sync.sv
// module: two-stage pin synchroniser with edge detection
`timescale 1ns/10ps
`default_nettype none
module tfa_pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  logic [W-1:0] meta; // first stage, read only by level
  logic [W-1:0] prev; // delayed copy for edges

  // two flops before any logic; edges look at stage two only
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      level <= '0;
      prev <= '0;
    end else begin
      meta <= pin;
      level <= meta;
      prev <= level;
    end
  end

  // short pulses may slip between samples; caller keeps them wide
  assign rise = level & ~prev;
  assign fall = ~level & prev;

endmodule : tfa_pin_sync
`default_nettype wire

// ===== tfa_timer_flags.sv
// module: timer counter, flags, interrupt and access conflict logic
`timescale 1ns/10ps
`default_nettype none
module tfa_timer_flags #(
  parameter int CNT_W = 16, // counter and general register width
  parameter int NUM_GR = 4 // number of general registers
) (
  input wire logic clk,
  input wire logic rst,
  input wire tfa_pkg::tfa_bus_req_t bus, // register request
  output logic [15:0] rdata, // valid the cycle after rd
  output logic irq, // level interrupt
  input wire logic ext_clk_pin, // external count clock pin
  input wire logic [NUM_GR-1:0] timer_io_pins_in, // pin levels in
  output logic [NUM_GR-1:0] timer_io_pins_out, // pin drive value
  output logic [NUM_GR-1:0] timer_io_pins_oe, // high while driving
  output logic [1:0] combination_mode_bits // to pwm mode logic
);

  // parameter sanity: the bus is 16 bits, map has room for 4 regs
  generate
    if (CNT_W < 2 || CNT_W > 16) begin : g_bad_w
      $error("counter width must be 2 to 16");
    end
    if (NUM_GR < 1 || NUM_GR > 4) begin : g_bad_n
      $error("general register count must be 1 to 4");
    end
  endgenerate

  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------

  // address of general register i
  function automatic logic [7:0] gr_addr(input int i);
    gr_addr = 8'(tfa_pkg::OFS_GR0 + 8'(i) * tfa_pkg::OFS_GR_STEP);
  endfunction : gr_addr

  // internal prescale tick: code k divides by 2**k, codes 0..5
  function automatic logic psc_tick(input logic [2:0] sel,
                                    input logic [4:0] pre);
    logic [4:0] mask;
    mask = 5'(({5'h0, 1'b1} << sel) - 6'h01);
    psc_tick = ((pre & mask) == mask);
  endfunction : psc_tick

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [4:0] ctrl; // run, prescaler_select, clear select
  logic [2*NUM_GR-1:0] ioen; // output enables and toggle enables
  logic [NUM_GR-1:0] initial_output_level_bits; // read-back value
  logic [CNT_W-1:0] timer_count_value; // the counter
  logic [CNT_W-1:0] general_compare_reg [NUM_GR]; // compare/capture
  logic [NUM_GR-1:0] match_capture_flag; // per general register
  logic overflow_flag; // counter rolled over
  logic [tfa_pkg::NUM_FLAGS-1:0] irq_enable; // interrupt mask
  logic [tfa_pkg::NUM_FLAGS-1:0] clr_armed; // flags seen as one
  logic [4:0] pre_cnt; // free running prescaler

  // views of the control fields
  logic run;
  logic [2:0] prescaler_select;
  logic clear_sel;
  logic [NUM_GR-1:0] toggle_en;
  logic [NUM_GR-1:0] capture_mode;
  assign run = ctrl[tfa_pkg::CTRL_RUN];
  assign prescaler_select = ctrl[tfa_pkg::CTRL_PSC_LO +: 3];
  assign clear_sel = ctrl[tfa_pkg::CTRL_CLR];
  assign toggle_en = ioen[tfa_pkg::IOEN_TGL_LO +: NUM_GR];
  // a general register captures when its pin is not driven
  assign capture_mode = ~timer_io_pins_oe;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic ext_rise; // external count clock edges
  logic ext_fall;
  logic [NUM_GR-1:0] cap_edge; // capture pin rising edges

  tfa_pin_sync #(.W(1)) u_ext_sync (
    .clk(clk),
    .rst(rst),
    .pin(ext_clk_pin),
    .level(),
    .rise(ext_rise),
    .fall(ext_fall)
  );

  tfa_pin_sync #(.W(NUM_GR)) u_cap_sync (
    .clk(clk),
    .rst(rst),
    .pin(timer_io_pins_in),
    .level(),
    .rise(cap_edge),
    .fall()
  );

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic wr_ctrl;
  logic wr_func;
  logic wr_ioen;
  logic wr_olvl;
  logic wr_stat;
  logic wr_mask;
  logic wr_cnt;
  logic rd_stat;
  logic [NUM_GR-1:0] wr_gr; // write strobe per general register

  assign wr_ctrl = bus.wr && bus.addr == tfa_pkg::OFS_CTRL;
  assign wr_func = bus.wr && bus.addr == tfa_pkg::OFS_FUNC;
  assign wr_ioen = bus.wr && bus.addr == tfa_pkg::OFS_IOEN;
  assign wr_olvl = bus.wr && bus.addr == tfa_pkg::OFS_OLVL;
  assign wr_stat = bus.wr && bus.addr == tfa_pkg::OFS_STAT;
  assign wr_mask = bus.wr && bus.addr == tfa_pkg::OFS_MASK;
  assign wr_cnt = bus.wr && bus.addr == tfa_pkg::OFS_CNT;
  assign rd_stat = bus.rd && bus.addr == tfa_pkg::OFS_STAT;

  // general register write decode, one per register
  always_comb begin
    for (int i = 0; i < NUM_GR; i++) begin
      wr_gr[i] = bus.wr && bus.addr == gr_addr(i);
    end
  end

  // ---------------------------------------------------------------
  // events
  // ---------------------------------------------------------------
  logic count_tick; // counter input clock
  logic [NUM_GR-1:0] cmp_match; // compare match signals
  logic [NUM_GR-1:0] capture; // input capture signals
  logic ovf_event; // rollover on this tick
  logic cnt_clear; // clear request from reg 0

  // count clock: internal prescale or external pin edge
  always_comb begin
    case (prescaler_select)
      tfa_pkg::PSC_EXT_RISE: count_tick = run && ext_rise;
      tfa_pkg::PSC_EXT_FALL: count_tick = run && ext_fall;
      default: count_tick = run && psc_tick(prescaler_select, pre_cnt);
    endcase
  end

  // match only fires when the counter would step at equality
  always_comb begin
    for (int i = 0; i < NUM_GR; i++) begin
      cmp_match[i] = count_tick && !capture_mode[i]
        && timer_count_value == general_compare_reg[i]
        && !wr_gr[i];
      capture[i] = capture_mode[i] && cap_edge[i];
    end
  end

  // rollover is seen even if a counter write lands now
  assign ovf_event = count_tick && timer_count_value == CNT_MAX;
  // reg 0 match or capture resets the count when selected
  assign cnt_clear = clear_sel && (cmp_match[0] || capture[0]);

  // ---------------------------------------------------------------
  // prescaler
  // ---------------------------------------------------------------
  // free running so every divide ratio shares one counter
  always_ff @(posedge clk) begin
    if (rst) begin
      pre_cnt <= 5'h00;
    end else begin
      pre_cnt <= pre_cnt + 5'h01;
    end
  end

  // ---------------------------------------------------------------
  // counter with conflict priority: clear, write, increment
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      timer_count_value <= CNT_ZERO;
    end else if (cnt_clear) begin
      // clear wins; any write and increment are dropped
      timer_count_value <= CNT_ZERO;
    end else if (wr_cnt) begin
      // write wins over the increment, even at rollover
      timer_count_value <= bus.wdata[CNT_W-1:0];
    end else if (count_tick) begin
      // wraps to zero at the top; flag is set separately
      timer_count_value <= timer_count_value + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // general registers: capture beats cpu write
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_GR; i++) begin
        general_compare_reg[i] <= '1;
      end
    end else begin
      for (int i = 0; i < NUM_GR; i++) begin
        if (capture[i]) begin
          // old count, from before any clear this cycle
          general_compare_reg[i] <= timer_count_value;
        end else if (wr_gr[i]) begin
          general_compare_reg[i] <= bus.wdata[CNT_W-1:0];
        end
      end
    end
  end
  // a write colliding with capture is simply lost above

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= 5'h00;
      ioen <= '0;
      irq_enable <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= bus.wdata[4:0];
      end
      if (wr_ioen) begin
        ioen <= bus.wdata[2*NUM_GR-1:0];
      end
      if (wr_mask) begin
        irq_enable <= bus.wdata[tfa_pkg::NUM_FLAGS-1:0];
      end
    end
  end

  // mode bits are stored as written; software keeps the counter
  // stopped and passes through normal mode when switching
  always_ff @(posedge clk) begin
    if (rst) begin
      combination_mode_bits <= 2'b00;
    end else if (wr_func) begin
      combination_mode_bits <= bus.wdata[1:0];
    end
  end

  // pin enables follow the io register so outputs stay registered
  always_ff @(posedge clk) begin
    if (rst) begin
      timer_io_pins_oe <= '0;
    end else if (wr_ioen) begin
      timer_io_pins_oe <= bus.wdata[NUM_GR-1:0];
    end
  end

  // ---------------------------------------------------------------
  // output levels
  // ---------------------------------------------------------------
  // written level drives the pin until a match toggles it; the
  // read-back bits do not follow later pin changes
  always_ff @(posedge clk) begin
    if (rst) begin
      initial_output_level_bits <= '0;
      timer_io_pins_out <= '0;
    end else if (wr_olvl) begin
      initial_output_level_bits <= bus.wdata[NUM_GR-1:0];
      // the write wins; a same-cycle match change is lost, so
      // read-modify-write of this register may undo a toggle
      timer_io_pins_out <= bus.wdata[NUM_GR-1:0];
    end else begin
      timer_io_pins_out <= timer_io_pins_out
        ^ (cmp_match & toggle_en);
    end
  end
  // software should stop, copy pin levels back, then restart

  // ---------------------------------------------------------------
  // status flags and read-then-write-zero clearing
  // ---------------------------------------------------------------
  logic [tfa_pkg::NUM_FLAGS-1:0] flags; // packed view
  logic [tfa_pkg::NUM_FLAGS-1:0] flag_set; // hardware events
  logic [tfa_pkg::NUM_FLAGS-1:0] flag_clr; // cpu clear requests
  assign flags = {overflow_flag, match_capture_flag};
  assign flag_set = {ovf_event, cmp_match | capture};
  // only bits read as one and then written zero clear
  assign flag_clr = wr_stat
    ? (clr_armed & ~bus.wdata[tfa_pkg::NUM_FLAGS-1:0]) : '0;

  // arming: a status read remembers which flags were one
  always_ff @(posedge clk) begin
    if (rst) begin
      clr_armed <= '0;
    end else if (rd_stat) begin
      clr_armed <= flags;
    end else if (wr_stat) begin
      clr_armed <= '0; // one write consumes the arming
    end
  end

  // set beats a same-cycle clear so no event is lost
  always_ff @(posedge clk) begin
    if (rst) begin
      match_capture_flag <= '0;
      overflow_flag <= 1'b0;
    end else begin
      match_capture_flag <= flag_set[NUM_GR-1:0]
        | (match_capture_flag & ~flag_clr[NUM_GR-1:0]);
      overflow_flag <= flag_set[tfa_pkg::STAT_OVF]
        | (overflow_flag & ~flag_clr[tfa_pkg::STAT_OVF]);
    end
  end

  // level interrupt from enabled flags
  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags & irq_enable);
    end
  end

  // ---------------------------------------------------------------
  // read data, one cycle after the strobe
  // ---------------------------------------------------------------
  logic [15:0] rd_mux; // combinational select

  // unmapped addresses read zero; narrow fields sit low
  always_comb begin
    rd_mux = tfa_pkg::RST_ZERO;
    case (bus.addr)
      tfa_pkg::OFS_CTRL: rd_mux = 16'(ctrl);
      tfa_pkg::OFS_FUNC: rd_mux = 16'(combination_mode_bits);
      tfa_pkg::OFS_IOEN: rd_mux = 16'(ioen);
      tfa_pkg::OFS_OLVL: rd_mux = 16'(initial_output_level_bits);
      tfa_pkg::OFS_STAT: rd_mux = 16'(flags);
      tfa_pkg::OFS_MASK: rd_mux = 16'(irq_enable);
      tfa_pkg::OFS_CNT: rd_mux = 16'(timer_count_value);
      default: begin
        for (int i = 0; i < NUM_GR; i++) begin
          if (bus.addr == gr_addr(i)) begin
            // pre-capture value: the capture lands at this edge
            rd_mux = 16'(general_compare_reg[i]);
          end
        end
      end
    endcase
  end

  // data stand only in the cycle after the read
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= tfa_pkg::RST_ZERO;
    end else if (bus.rd) begin
      rdata <= rd_mux;
    end else begin
      rdata <= tfa_pkg::RST_ZERO;
    end
  end

endmodule : tfa_timer_flags
`default_nettype wire

// ===== tfa_timer_flags_asserts.sv
// checker: port assertions of the timer flag and conflict arbiter
`timescale 1ns/10ps
`default_nettype none
module tfa_timer_flags_asserts #(
  parameter int CNT_W = 16, // counter width, handed on by the bind
  parameter int NUM_GR = 4 // general registers and pins
) (
  input wire logic clk,
  input wire logic rst,
  input wire tfa_pkg::tfa_bus_req_t bus,
  input wire logic [15:0] rdata,
  input wire logic irq,
  input wire logic ext_clk_pin,
  input wire logic [NUM_GR-1:0] timer_io_pins_in,
  input wire logic [NUM_GR-1:0] timer_io_pins_out,
  input wire logic [NUM_GR-1:0] timer_io_pins_oe,
  input wire logic [1:0] combination_mode_bits
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic wr_stat; // status write
  logic wr_mask; // mask write
  logic wr_olvl; // output level write
  logic wr_func; // mode write
  logic wr_ioen; // pin enable write
  logic [15:0] wdata_q; // write data one cycle back
  logic [NUM_GR-1:0] tgl; // shadow of the toggle enables
  logic [tfa_pkg::NUM_FLAGS-1:0] mask; // shadow of interrupt enables
  logic armed; // status read since the last status write
  logic [1:0] clr_seen; // status or mask write, or reset, lately

  assign wr_stat = bus.wr && bus.addr == tfa_pkg::OFS_STAT;
  assign wr_mask = bus.wr && bus.addr == tfa_pkg::OFS_MASK;
  assign wr_olvl = bus.wr && bus.addr == tfa_pkg::OFS_OLVL;
  assign wr_func = bus.wr && bus.addr == tfa_pkg::OFS_FUNC;
  assign wr_ioen = bus.wr && bus.addr == tfa_pkg::OFS_IOEN;

  // history; a registered irq may fall two cycles after its clear
  always_ff @(posedge clk) begin
    wdata_q <= bus.wdata;
    clr_seen <= {clr_seen[0], rst | wr_stat | wr_mask};
  end
  // shadows of the enable registers
  always_ff @(posedge clk) begin
    if (rst) begin
      tgl <= '0;
      mask <= '0;
    end else begin
      if (wr_ioen)
        tgl <= bus.wdata[tfa_pkg::IOEN_TGL_LO +: NUM_GR];
      if (wr_mask)
        mask <= bus.wdata[tfa_pkg::NUM_FLAGS-1:0];
    end
  end
  // coarse: any status read arms, which only weakens the check
  always_ff @(posedge clk) begin
    if (rst || wr_stat)
      armed <= 1'b0;
    else if (bus.rd && bus.addr == tfa_pkg::OFS_STAT)
      armed <= 1'b1;
  end

  chk_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 16'h0000)
    else $error("read data not zero outside a read answer");
  chk_mode_load: assert property (wr_func |=>
    combination_mode_bits == wdata_q[1:0])
    else $error("mode bits differ from written value");
  chk_mode_hold: assert property (!wr_func |=>
    $stable(combination_mode_bits))
    else $error("mode bits changed without a write");
  chk_level_load: assert property (wr_olvl |=>
    timer_io_pins_out == wdata_q[NUM_GR-1:0])
    else $error("pin level differs from level write");
  chk_level_hold: assert property (tgl == '0 && !wr_olvl |=>
    $stable(timer_io_pins_out))
    else $error("pin level moved with no toggle enabled");
  chk_oe_load: assert property (wr_ioen |=>
    timer_io_pins_oe == wdata_q[NUM_GR-1:0])
    else $error("pin enable differs from written value");
  chk_irq_masked: assert property (mask == '0 && !wr_mask |=> !irq)
    else $error("interrupt raised with all enables off");
  chk_irq_cause: assert property ($fell(irq) |-> clr_seen != 2'b00)
    else $error("interrupt fell without a status or mask write");
  chk_unarmed_keep: assert property (irq && wr_stat && !armed &&
    clr_seen == 2'b00 |=> irq)
    else $error("flag cleared without a prior read");
  chk_ones_keep: assert property (irq && wr_stat && clr_seen == 2'b00 &&
    bus.wdata[4:0] == 5'h1f |=> irq)
    else $error("flag cleared by writing ones");

  cov_irq_rise: cover property ($rose(irq));
  cov_stat_clear: cover property (irq ##1 wr_stat ##2 !irq);
  cov_level_write: cover property (wr_olvl && tgl != '0);
  cov_ext_clock: cover property ($rose(ext_clk_pin));
  cov_capture: cover property ($rose(timer_io_pins_in[0]));
endmodule : tfa_timer_flags_asserts

bind tfa_timer_flags tfa_timer_flags_asserts #(
  .CNT_W(CNT_W), .NUM_GR(NUM_GR)
) u_chk (
  .clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .irq(irq),
  .ext_clk_pin(ext_clk_pin), .timer_io_pins_in(timer_io_pins_in),
  .timer_io_pins_out(timer_io_pins_out),
  .timer_io_pins_oe(timer_io_pins_oe),
  .combination_mode_bits(combination_mode_bits)
);
`default_nettype wire

// ===== tfa_pin_model.sv
// model: the outside world driving the timer pins and count clock
`timescale 1ns/10ps
`default_nettype none
module tfa_pin_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic go, // start a pulse on the selected lines
  input wire logic [4:0] sel, // [3:0] io pins, [4] external clock
  input wire logic [2:0] len, // wanted width in clocks
  output logic [3:0] pins, // capture inputs of the timer
  output logic ext // external count clock
);
  logic [4:0] lines; // lines now held high
  logic [2:0] left; // clocks still to hold

  assign pins = lines[3:0];
  assign ext = lines[4];

  // one pulse at a time; lines rest low between pulses
  always_ff @(posedge clk) begin
    if (rst) begin
      lines <= 5'h00;
      left <= 3'h0;
    end else if (go) begin
      lines <= sel;
      left <= (len < 3'h3) ? 3'h3 : len;
    end else if (left != 3'h0) begin
      left <= left - 3'h1;
      if (left == 3'h1)
        lines <= 5'h00;
    end
  end
endmodule : tfa_pin_model
`default_nettype wire

// ===== timer_flag_and_conflict_arbiter_tb_top.sv
// testbench: top level for the timer flag and conflict arbiter
`timescale 1ns/10ps
`default_nettype none
module timer_flag_and_conflict_arbiter_tb_top;
  logic clk = 1'b0; // 125 MHz
  logic rst = 1'b1; // synchronous, active high
  tfa_pkg::tfa_bus_req_t bus = '0; // register request
  logic [15:0] rdata;
  logic irq;
  logic ext; // external count clock from the model
  logic [3:0] pins_in; // capture pins from the model
  logic [3:0] pins_out;
  logic [3:0] pins_oe;
  logic [1:0] mode;
  logic go = 1'b0; // model pulse request
  logic [4:0] sel = 5'h00;
  logic [2:0] len = 3'h3;
  logic [31:0] seed = 32'h7fb2; // fixed seed, repeatable runs
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;

  always #4 clk = ~clk;

  tfa_timer_flags DUT (
    .clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .irq(irq),
    .ext_clk_pin(ext), .timer_io_pins_in(pins_in),
    .timer_io_pins_out(pins_out), .timer_io_pins_oe(pins_oe),
    .combination_mode_bits(mode)
  );
  tfa_pin_model u_model (
    .clk(clk), .rst(rst), .go(go), .sel(sel), .len(len),
    .pins(pins_in), .ext(ext)
  );

  // next value of the pseudo-random sequence
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // control word built from its fields
  function automatic logic [15:0] ctrl(input logic [2:0] psc,
      input logic run, input logic clr);
    logic [15:0] w;
    w = 16'h0000;
    w[tfa_pkg::CTRL_RUN] = run;
    w[tfa_pkg::CTRL_PSC_LO +: 3] = psc;
    w[tfa_pkg::CTRL_CLR] = clr;
    return w;
  endfunction : ctrl
  // byte address of general register i
  function automatic logic [7:0] gr(input int i);
    return tfa_pkg::OFS_GR0 + 8'(i) * tfa_pkg::OFS_GR_STEP;
  endfunction : gr

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chkp(input logic [3:0] got, input logic [3:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chkp
  // write and read tasks leave the strobe up so requests may follow back to back
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    #1;
  endtask : wr
  // answer stands only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    #1;
    chk(rdata, exp);
  endtask : rdc
  task automatic idle(input int n);
    bus <= '0;
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  // pulse, then wait out synchroniser and edge detect
  task automatic pulse(input logic [4:0] s, input logic [2:0] l);
    bus <= '0;
    go <= 1'b1;
    sel <= s;
    len <= l;
    @(posedge clk);
    #1;
    go <= 1'b0;
    repeat (int'(l) + 6) @(posedge clk);
    #1;
  endtask : pulse
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  // hang guard, well above the length of the sequence
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      finish_test();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    #1;
    rst <= 1'b0;
    // reset values; 0x1c is unmapped and reads zero
    for (int i = 0; i < 8; i++)
      rdc(8'(i * 4), 16'h0000);
    for (int i = 0; i < 4; i++)
      rdc(gr(i), 16'hffff);
    chk({5'h00, irq, mode, pins_oe, pins_out}, 16'h0000);
    $display("test reset done");
    // random register traffic with the counter stopped
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      wr(gr(i % 4), seed[15:0]);
      wr(tfa_pkg::OFS_FUNC, 16'h0000);
      wr(tfa_pkg::OFS_FUNC, {14'h0000, seed[17:16]});
      wr(tfa_pkg::OFS_CNT, ~seed[15:0]);
      wr(tfa_pkg::OFS_MASK, {11'h000, seed[20:16]});
      wr(8'h3c, seed[15:0]);
      rdc(gr(i % 4), seed[15:0]);
      rdc(tfa_pkg::OFS_CNT, ~seed[15:0]);
      rdc(tfa_pkg::OFS_MASK, {11'h000, seed[20:16]});
      rdc(8'h3c, 16'h0000);
      chkp({2'h0, mode}, {2'h0, seed[17:16]});
    end
    wr(tfa_pkg::OFS_MASK, 16'h0000);
    wr(tfa_pkg::OFS_FUNC, 16'h0000);
    $display("test random done");
    // overflow lands on a count write
    wr(tfa_pkg::OFS_CTRL, ctrl(3'h0, 1'b1, 1'b0));
    wr(tfa_pkg::OFS_CNT, 16'hffff);
    wr(tfa_pkg::OFS_CNT, 16'h1234);
    wr(tfa_pkg::OFS_CTRL, 16'h0000);
    idle(2);
    chkp({3'h0, irq}, 4'h0);
    rdc(tfa_pkg::OFS_CNT, 16'h1235);
    wr(tfa_pkg::OFS_MASK, 16'h0001 << tfa_pkg::STAT_OVF);
    wr(tfa_pkg::OFS_STAT, 16'h0000);
    idle(2);
    chkp({3'h0, irq}, 4'h1);
    wr(tfa_pkg::OFS_STAT, 16'h0000);
    idle(2);
    rdc(tfa_pkg::OFS_STAT, 16'h0001 << tfa_pkg::STAT_OVF);
    wr(tfa_pkg::OFS_STAT, 16'h001f);
    idle(2);
    chkp({3'h0, irq}, 4'h1);
    rdc(tfa_pkg::OFS_STAT, 16'h0001 << tfa_pkg::STAT_OVF);
    wr(tfa_pkg::OFS_STAT, 16'h0000);
    idle(2);
    chkp({3'h0, irq}, 4'h0);
    rdc(tfa_pkg::OFS_STAT, 16'h0000);
    $display("test overflow done");
    // clear on match beats a count write, then write beats match
    wr(gr(0), 16'h0010);
    wr(tfa_pkg::OFS_IOEN, 16'h0001);
    wr(tfa_pkg::OFS_CTRL, ctrl(3'h0, 1'b1, 1'b1));
    wr(tfa_pkg::OFS_CNT, 16'h0010);
    wr(tfa_pkg::OFS_CNT, 16'h0500);
    wr(tfa_pkg::OFS_CTRL, 16'h0000);
    rdc(tfa_pkg::OFS_CNT, 16'h0001);
    rdc(tfa_pkg::OFS_STAT, 16'h0001);
    wr(tfa_pkg::OFS_STAT, 16'h0000);
    wr(tfa_pkg::OFS_CTRL, ctrl(3'h0, 1'b1, 1'b1));
    wr(tfa_pkg::OFS_CNT, 16'h0010);
    wr(gr(0), 16'h0020);
    wr(tfa_pkg::OFS_CTRL, 16'h0000);
    rdc(tfa_pkg::OFS_CNT, 16'h0012);
    rdc(tfa_pkg::OFS_STAT, 16'h0000);
    $display("test match done");
    // pin level: set, then write meets match, then match alone
    wr(tfa_pkg::OFS_IOEN, 16'h0011);
    wr(tfa_pkg::OFS_OLVL, 16'h0001);
    wr(gr(0), 16'h0010);
    chkp(pins_out, 4'h1);
    wr(tfa_pkg::OFS_CTRL, ctrl(3'h0, 1'b1, 1'b0));
    wr(tfa_pkg::OFS_CNT, 16'h0010);
    wr(tfa_pkg::OFS_OLVL, 16'h0001);
    wr(tfa_pkg::OFS_CTRL, 16'h0000);
    idle(2);
    chkp(pins_out, 4'h1);
    wr(tfa_pkg::OFS_CTRL, ctrl(3'h0, 1'b1, 1'b0));
    wr(tfa_pkg::OFS_CNT, 16'h0010);
    wr(tfa_pkg::OFS_CTRL, 16'h0000);
    idle(2);
    chkp(pins_out, 4'h0);
    $display("test pins done");
    // capture on two pins at once, register 0 clears the count
    wr(tfa_pkg::OFS_IOEN, 16'h0000);
    wr(tfa_pkg::OFS_CTRL, ctrl(3'h0, 1'b0, 1'b1));
    wr(tfa_pkg::OFS_CNT, 16'h0abc);
    rdc(tfa_pkg::OFS_STAT, 16'h0001);
    wr(tfa_pkg::OFS_STAT, 16'h0000);
    pulse(5'h03, 3'h3);
    rdc(gr(0), 16'h0abc);
    rdc(gr(1), 16'h0abc);
    rdc(tfa_pkg::OFS_CNT, 16'h0000);
    rdc(tfa_pkg::OFS_STAT, 16'h0003);
    for (int i = 2; i < 4; i++) begin
      seed = lfsr(seed);
      wr(tfa_pkg::OFS_CNT, seed[15:0]);
      pulse(5'(1 << i), 3'h3 + {1'b0, seed[17:16]});
      rdc(gr(i), seed[15:0]);
    end
    // capture lands in the second state of a read, then of a write
    for (int i = 2; i < 4; i++) begin
      go <= 1'b1;
      sel <= 5'(1 << i);
      len <= 3'h3;
      wr(gr(i), 16'h0555);
      go <= 1'b0;
      wr(tfa_pkg::OFS_CNT, 16'h0777);
      idle(1);
      if (i == 2)
        rdc(gr(i), 16'h0555);
      else
        wr(gr(i), 16'h0999);
      rdc(gr(i), 16'h0777);
    end
    $display("test capture done");
    // external count clock, rising then falling edges
    for (int k = 0; k < 2; k++) begin
      wr(tfa_pkg::OFS_CNT, 16'h0000);
      wr(tfa_pkg::OFS_CTRL, ctrl(k == 0 ? tfa_pkg::PSC_EXT_RISE :
        tfa_pkg::PSC_EXT_FALL, 1'b1, 1'b0));
      repeat (3) pulse(5'h10, 3'h3);
      wr(tfa_pkg::OFS_CTRL, 16'h0000);
      rdc(tfa_pkg::OFS_CNT, 16'h0003);
    end
    idle(1);
    $display("test external clock done");
    finish_test();
  end
endmodule : timer_flag_and_conflict_arbiter_tb_top
`default_nettype wire
